// *** verilog/light_prox_defines.vh ***
`ifndef LIGHT_PROX_DEFINES_VH
`define LIGHT_PROX_DEFINES_VH

// ---------------------------------------------------------------
// bus address and register indices
// ---------------------------------------------------------------
`define SLAVE_ADDR 7'h44
`define REG_OPERATION_CONTROL 4'h0
`define REG_SENSING_CONFIG 4'h1
`define REG_RESULT_LOW 4'h2
`define REG_RESULT_HIGH 4'h3
`define REG_LOW_THR_LOW 4'h4
`define REG_LOW_THR_HIGH 4'h5
`define REG_HIGH_THR_LOW 4'h6
`define REG_HIGH_THR_HIGH 4'h7
`define REG_RESERVED 4'h8

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_BYTE_ZERO 8'h00
`define RST_BYTE_ONES 8'hff

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define MODE_MSB 7
`define MODE_LSB 5
`define FLAG_BIT 2
`define PERSIST_MSB 1
`define PERSIST_LSB 0
`define SCHEME_BIT 7
`define MOD_BIT 6
`define CURR_MSB 5
`define CURR_LSB 4
`define RES_MSB 3
`define RES_LSB 2
`define FSR_MSB 1
`define FSR_LSB 0

// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define MODE_OFF 3'h0
`define MODE_RSVD 3'h4
`define MODE_CONT_BIT 2

// ---------------------------------------------------------------
// resolution codes and conversion lengths in oscillator clocks
// ---------------------------------------------------------------
`define RES_16 2'h0
`define RES_12 2'h1
`define RES_8 2'h2
`define RES_4 2'h3
`define CONV_LEN_16 17'h1_0000
`define CONV_LEN_12 17'h0_1000
`define CONV_LEN_8 17'h0_0100
`define CONV_LEN_4 17'h0_0010

// ---------------------------------------------------------------
// persistence counts
// ---------------------------------------------------------------
`define PERSIST_1 5'h01
`define PERSIST_4 5'h04
`define PERSIST_8 5'h08
`define PERSIST_16 5'h10

`endif

// *** verilog/pin_sync.v ***
`default_nettype none

// two-flop synchroniser for one asynchronous level
module pin_sync (
    input wire clk_sys,
    input wire rst_n,
    input wire pin_in,
    output wire pin_out
);
    reg meta_q;
    reg sync_q;

    // first stage feeds the second stage only
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_out = sync_q;
endmodule

`default_nettype wire

// *** verilog/conversion_seq.v ***
`default_nettype none
`include "light_prox_defines.vh"

// conversion sequencer: counts oscillator ticks, captures adc result
module conversion_seq (
    input wire clk_sys,
    input wire rst_n,
    input wire [2:0] mode,
    input wire [1:0] res_code,
    input wire scheme,
    input wire osc_tick,
    input wire [15:0] adc_sample,
    output reg conv_busy_q,
    output reg conv_done_q,
    output reg [15:0] result_q,
    output wire oneshot_done
);
    reg [16:0] count_q;
    reg [16:0] conv_len;
    reg [15:0] sample_mask;
    reg [15:0] shaped;
    wire mode_active;
    wire is_prox;

    assign mode_active = (mode != `MODE_OFF) && (mode != `MODE_RSVD);
    assign is_prox = (mode[1:0] == 2'b11);
    assign oneshot_done = conv_done_q && !mode[`MODE_CONT_BIT];

    // conversion length and sign position from the resolution code
    always @* begin
        case (res_code)
            `RES_12: begin
                conv_len = `CONV_LEN_12;
                sample_mask = 16'h0fff;
            end
            `RES_8: begin
                conv_len = `CONV_LEN_8;
                sample_mask = 16'h00ff;
            end
            `RES_4: begin
                conv_len = `CONV_LEN_4;
                sample_mask = 16'h000f;
            end
            default: begin
                conv_len = `CONV_LEN_16;
                sample_mask = 16'hffff;
            end
        endcase
    end

    // right-aligned result, sign-extended in proximity mode under the ambient-subtracting scheme
    always @* begin
        shaped = adc_sample & sample_mask;
        if (is_prox && scheme) begin
            if ((shaped & ~(sample_mask >> 1)) != 16'h0000) begin
                shaped = shaped | ~(sample_mask >> 1);
            end
        end
    end

    // count integration clocks and refresh the result at the end
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            count_q <= 17'h0_0000;
            conv_busy_q <= 1'b0;
            conv_done_q <= 1'b0;
            result_q <= 16'h0000;
        end else begin
            conv_done_q <= 1'b0;
            if (!mode_active || conv_done_q) begin
                count_q <= 17'h0_0000;
                conv_busy_q <= 1'b0;
            end else if (osc_tick) begin
                conv_busy_q <= 1'b1;
                if (count_q + 17'h0_0001 >= conv_len) begin
                    count_q <= 17'h0_0000;
                    conv_done_q <= 1'b1;
                    result_q <= shaped;
                end else begin
                    count_q <= count_q + 17'h0_0001;
                end
            end
        end
    end
endmodule

`default_nettype wire

// *** verilog/light_proximity_sensor_ctrl.v ***
`default_nettype none
`include "light_prox_defines.vh"

// Operation
// - answer only address 1000100 after start; eighth bit is read/write
// - eight byte registers; command registers keep values until rewritten
// - receiver acknowledges by pulling data low; master alone drives clock
// - mode field bits 7:5 selects power-down, once or continuous sensing
// - one-shot modes convert once, keep result, then power down themselves
// - continuous modes convert repeatedly, overwriting results until power-down
// - result above high or below low threshold is an interrupt event
// - trigger sets flag bit 2 and drives interrupt low until cleared
// - flag and interrupt clear when a transfer of register zero completes
// - interrupt after m consecutive events; persist code gives 1,4,8,16
// - scheme bit 7 picks unsigned or ambient-subtracted signed proximity
// - signed proximity result is sign-extended below 16 bit resolution
// - bit 6 picks steady or 360 kHz led modulation
// - bits 5:4 go to the led current source as drive code
// - bits 3:2 set conversion length and resolution
// - bits 1:0 select full-scale range sent to analog front end
// - result readable, low byte index 2, high byte index 3
// - results right-aligned with D0 least significant
// - both result registers refresh at end of each conversion
// - indices 4 and 5 hold low threshold, reset zero
// - indices 6 and 7 hold high threshold, reset FF
// - index 8 is reserved and reads 00h
module light_proximity_sensor_ctrl (
    input wire clk_sys,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_q,
    output wire int_n_out,
    output reg int_n_oe_q,
    input wire osc_tick,
    input wire [15:0] adc_sample,
    output reg [2:0] sense_mode_q,
    output reg led_modulation_select_q,
    output reg [1:0] led_current_q,
    output reg [1:0] full_scale_q,
    output reg led_drive_out_q,
    output reg conv_active_q
);
    // -----------------------------------------------------------
    // bus states
    // -----------------------------------------------------------
    localparam [5:0] ST_IDLE = 6'b000001;
    localparam [5:0] ST_ADDR = 6'b000010;
    localparam [5:0] ST_ACK = 6'b000100;
    localparam [5:0] ST_WRITE = 6'b001000;
    localparam [5:0] ST_READ = 6'b010000;
    localparam [5:0] ST_RACK = 6'b100000;

    wire scl_s;
    wire sda_s;
    reg scl_d1_q;
    reg sda_d1_q;
    reg [5:0] state_q;
    reg [7:0] shift_q;
    reg [3:0] bit_cnt_q;
    reg rw_q;
    reg index_phase_q;
    reg [3:0] index_q;
    reg touched_op_q;
    reg [7:0] op_ctrl_q;
    reg [7:0] sense_cfg_q;
    reg [7:0] lt_lo_q;
    reg [7:0] lt_hi_q;
    reg [7:0] ht_lo_q;
    reg [7:0] ht_hi_q;
    reg flag_q;
    reg [4:0] persist_cnt_q;
    reg [4:0] persist_need;
    reg [7:0] rd_data;
    reg [3:0] mod_div_q;
    wire start_cond;
    wire stop_cond;
    wire scl_rise;
    wire scl_fall;
    wire conv_busy;
    wire conv_done;
    wire [15:0] result;
    wire oneshot_done;
    wire out_of_window;
    wire op_done;
    wire hit_op;

    // -----------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------
    pin_sync u_scl_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(scl_in),
        .pin_out(scl_s)
    );

    pin_sync u_sda_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(sda_in),
        .pin_out(sda_s)
    );

    // edge detection on synchronised lines
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            scl_d1_q <= scl_s;
            sda_d1_q <= sda_s;
        end
    end

    assign start_cond = scl_s && scl_d1_q && sda_d1_q && !sda_s;
    assign stop_cond = scl_s && scl_d1_q && !sda_d1_q && sda_s;
    assign scl_rise = scl_s && !scl_d1_q;
    assign scl_fall = !scl_s && scl_d1_q;

    // open-drain lines only ever pull low
    assign sda_out = 1'b0;
    assign int_n_out = 1'b0;

    // -----------------------------------------------------------
    // register read mux
    // -----------------------------------------------------------
    always @* begin
        case (index_q)
            `REG_OPERATION_CONTROL: rd_data = {op_ctrl_q[7:3], flag_q, op_ctrl_q[1:0]};
            `REG_SENSING_CONFIG: rd_data = sense_cfg_q;
            `REG_RESULT_LOW: rd_data = result[7:0];
            `REG_RESULT_HIGH: rd_data = result[15:8];
            `REG_LOW_THR_LOW: rd_data = lt_lo_q;
            `REG_LOW_THR_HIGH: rd_data = lt_hi_q;
            `REG_HIGH_THR_LOW: rd_data = ht_lo_q;
            `REG_HIGH_THR_HIGH: rd_data = ht_hi_q;
            default: rd_data = `RST_BYTE_ZERO;
        endcase
    end

    assign hit_op = (index_q == `REG_OPERATION_CONTROL);
    assign op_done = (stop_cond || start_cond) && touched_op_q;

    // -----------------------------------------------------------
    // bus slave state machine and register writes
    // -----------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            rw_q <= 1'b0;
            index_phase_q <= 1'b0;
            index_q <= 4'h0;
            touched_op_q <= 1'b0;
            sda_oe_q <= 1'b0;
            op_ctrl_q <= `RST_BYTE_ZERO;
            sense_cfg_q <= `RST_BYTE_ZERO;
            lt_lo_q <= `RST_BYTE_ZERO;
            lt_hi_q <= `RST_BYTE_ZERO;
            ht_lo_q <= `RST_BYTE_ONES;
            ht_hi_q <= `RST_BYTE_ONES;
        end else begin
            if (oneshot_done) begin
                op_ctrl_q[`MODE_MSB:`MODE_LSB] <= `MODE_OFF;
            end
            if (op_done) begin
                touched_op_q <= 1'b0;
            end
            if (stop_cond) begin
                state_q <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end else if (start_cond) begin
                state_q <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        if (scl_fall && bit_cnt_q == 4'h8) begin
                            if (shift_q[7:1] == `SLAVE_ADDR) begin
                                rw_q <= shift_q[0];
                                index_phase_q <= !shift_q[0];
                                sda_oe_q <= 1'b1;
                                state_q <= ST_ACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (rw_q) begin
                                shift_q <= rd_data;
                                sda_oe_q <= !rd_data[7];
                                touched_op_q <= touched_op_q | hit_op;
                                state_q <= ST_READ;
                            end else begin
                                sda_oe_q <= 1'b0;
                                state_q <= ST_WRITE;
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        if (scl_fall && bit_cnt_q == 4'h8) begin
                            sda_oe_q <= 1'b1;
                            state_q <= ST_ACK;
                            if (index_phase_q) begin
                                index_q <= shift_q[3:0];
                                index_phase_q <= 1'b0;
                            end else begin
                                case (index_q)
                                    `REG_OPERATION_CONTROL: begin
                                        op_ctrl_q <= {shift_q[7:5], 2'b00, 1'b0, shift_q[1:0]};
                                        touched_op_q <= 1'b1;
                                    end
                                    `REG_SENSING_CONFIG: sense_cfg_q <= shift_q;
                                    `REG_LOW_THR_LOW: lt_lo_q <= shift_q;
                                    `REG_LOW_THR_HIGH: lt_hi_q <= shift_q;
                                    `REG_HIGH_THR_LOW: ht_lo_q <= shift_q;
                                    `REG_HIGH_THR_HIGH: ht_hi_q <= shift_q;
                                    default: ;
                                endcase
                                index_q <= index_q + 4'h1;
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        if (scl_fall) begin
                            if (bit_cnt_q == 4'h8) begin
                                sda_oe_q <= 1'b0;
                                index_q <= index_q + 4'h1;
                                state_q <= ST_RACK;
                            end else begin
                                shift_q <= {shift_q[6:0], 1'b0};
                                sda_oe_q <= !shift_q[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            if (sda_s) begin
                                state_q <= ST_IDLE; // master ended the read
                            end else begin
                                state_q <= ST_ACK;
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // -----------------------------------------------------------
    // conversion sequencer
    // -----------------------------------------------------------
    conversion_seq u_conv (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .mode(op_ctrl_q[`MODE_MSB:`MODE_LSB]),
        .res_code(sense_cfg_q[`RES_MSB:`RES_LSB]),
        .scheme(sense_cfg_q[`SCHEME_BIT]),
        .osc_tick(osc_tick),
        .adc_sample(adc_sample),
        .conv_busy_q(conv_busy),
        .conv_done_q(conv_done),
        .result_q(result),
        .oneshot_done(oneshot_done)
    );

    // -----------------------------------------------------------
    // threshold window and persistence
    // -----------------------------------------------------------
    assign out_of_window = (result > {ht_hi_q, ht_lo_q}) ||
        (result < {lt_hi_q, lt_lo_q});

    always @* begin
        case (op_ctrl_q[`PERSIST_MSB:`PERSIST_LSB])
            2'b01: persist_need = `PERSIST_4;
            2'b10: persist_need = `PERSIST_8;
            2'b11: persist_need = `PERSIST_16;
            default: persist_need = `PERSIST_1;
        endcase
    end

    // sticky flag; a new trigger wins over the clear
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            persist_cnt_q <= 5'h00;
            flag_q <= 1'b0;
            int_n_oe_q <= 1'b0;
        end else begin
            if (conv_done) begin
                if (out_of_window) begin
                    if (persist_cnt_q + 5'h01 >= persist_need) begin
                        flag_q <= 1'b1;
                        int_n_oe_q <= 1'b1;
                        persist_cnt_q <= 5'h00;
                    end else begin
                        persist_cnt_q <= persist_cnt_q + 5'h01;
                    end
                end else begin
                    persist_cnt_q <= 5'h00;
                end
            end
            if (op_done && !(conv_done && out_of_window &&
                    persist_cnt_q + 5'h01 >= persist_need)) begin
                flag_q <= 1'b0;
                int_n_oe_q <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------
    // analog front end control codes and led drive
    // -----------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sense_mode_q <= `MODE_OFF;
            led_modulation_select_q <= 1'b0;
            led_current_q <= 2'b00;
            full_scale_q <= 2'b00;
            led_drive_out_q <= 1'b0;
            conv_active_q <= 1'b0;
            mod_div_q <= 4'h0;
        end else begin
            sense_mode_q <= op_ctrl_q[`MODE_MSB:`MODE_LSB];
            led_modulation_select_q <= sense_cfg_q[`MOD_BIT];
            led_current_q <= sense_cfg_q[`CURR_MSB:`CURR_LSB];
            full_scale_q <= sense_cfg_q[`FSR_MSB:`FSR_LSB];
            conv_active_q <= conv_busy;
            mod_div_q <= osc_tick ? mod_div_q + 4'h1 : mod_div_q;
            if (conv_busy && op_ctrl_q[`MODE_LSB + 1:`MODE_LSB] == 2'b11) begin
                led_drive_out_q <= sense_cfg_q[`MOD_BIT] ? mod_div_q[0] : 1'b1;
            end else begin
                led_drive_out_q <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** verification/light_proximity_sensor_ctrl_asserts.sv ***
`default_nettype none
module light_prox_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_q,
    input wire logic int_n_out,
    input wire logic int_n_oe_q,
    input wire logic osc_tick,
    input wire logic [2:0] sense_mode_q,
    input wire logic led_modulation_select_q,
    input wire logic [1:0] led_current_q,
    input wire logic [1:0] full_scale_q,
    input wire logic led_drive_out_q,
    input wire logic conv_active_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic scl_prev_q;
    logic [7:0] idle_q;
    // cycles since the bus clock last moved
    always @(posedge clk_sys) begin
        scl_prev_q <= scl_in;
        if (!rst_n || scl_in != scl_prev_q) begin
            idle_q <= 8'h00;
        end else if (idle_q != 8'hff) begin
            idle_q <= idle_q + 8'h01;
        end
    end
    AST_OPEN_DRAIN: assert property (sda_out == 1'b0 && int_n_out == 1'b0)
        else $error("open drain pin driven high");
    AST_IDLE_RELEASE: assert property (scl_in [*8] |-> !sda_oe_q)
        else $error("data pulled low with bus clock idle");
    AST_INT_CLEAR_FRAME: assert property ($fell(int_n_oe_q) |-> scl_in)
        else $error("interrupt cleared outside a frame edge");
    AST_INT_SET_CONV: assert property ($rose(int_n_oe_q) |->
        $past(osc_tick) || $past(osc_tick, 2) || $past(osc_tick, 3))
        else $error("interrupt raised away from a conversion end");
    AST_LED_PROX_ONLY: assert property (led_drive_out_q |->
        sense_mode_q[1:0] == 2'b11 || $past(sense_mode_q[1:0]) == 2'b11)
        else $error("led driven outside proximity mode");
    AST_CONV_MODE: assert property ($rose(conv_active_q) |-> sense_mode_q[1:0] != 2'b00)
        else $error("conversion started in an idle mode");
    AST_CFG_HOLD: assert property ($changed({led_current_q, full_scale_q,
        led_modulation_select_q}) |-> idle_q < 8'h10)
        else $error("config output changed without bus traffic");
    AST_LED_DC: assert property (!led_modulation_select_q && conv_active_q
        && $past(conv_active_q, 2) && sense_mode_q[1:0] == 2'b11
        && $past(sense_mode_q[1:0], 2) == 2'b11 |-> led_drive_out_q)
        else $error("steady led drive dropped");
    cover property ($rose(int_n_oe_q));
    cover property ($fell(conv_active_q));
    cover property ($rose(led_drive_out_q));
endmodule

bind light_proximity_sensor_ctrl light_prox_checker light_prox_checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_q(sda_oe_q), .int_n_out(int_n_out), .int_n_oe_q(int_n_oe_q),
    .osc_tick(osc_tick), .sense_mode_q(sense_mode_q),
    .led_modulation_select_q(led_modulation_select_q), .led_current_q(led_current_q),
    .full_scale_q(full_scale_q), .led_drive_out_q(led_drive_out_q),
    .conv_active_q(conv_active_q)
);
`default_nettype wire

// *** verification/i2c_host_model.sv ***
`default_nettype none
// bus master: drives the clock, pulls data low or releases it to the pull-up
module i2c_host_model (
    input wire logic clk_sys,
    input wire logic sda_line,
    output var logic scl_q,
    output var logic sda_low_q
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_q = 1'b1;
        sda_low_q = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // one bit: data moves mid low phase, sampled mid high phase
    task automatic bit_x(input logic b, output logic r);
        wt(2);
        sda_low_q = !b;
        wt(2);
        scl_q = 1'b1;
        wt(2);
        r = sda_line;
        wt(2);
        scl_q = 1'b0;
    endtask
    task automatic start_x();
        wt(4);
        sda_low_q = 1'b1;
        wt(4);
        scl_q = 1'b0;
    endtask
    task automatic stop_x();
        wt(2);
        sda_low_q = 1'b1;
        wt(2);
        scl_q = 1'b1;
        wt(4);
        sda_low_q = 1'b0;
        wt(8);
    endtask
    // msb first, ninth bit is the acknowledge
    task automatic byte_x(input logic [7:0] d, input logic nack, output logic [7:0] q,
                          output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(nack, r);
        ack = !r;
    endtask
    // index byte then two data bytes, low byte first
    task automatic wr(input logic [6:0] adr, input logic [3:0] idx, input logic [15:0] d,
                      output logic ok);
        logic [7:0] q;
        logic a;
        start_x();
        byte_x({adr, 1'b0}, 1'b1, q, ok);
        if (ok) begin
            byte_x({4'h0, idx}, 1'b1, q, a);
            byte_x(d[7:0], 1'b1, q, a);
            byte_x(d[15:8], 1'b1, q, a);
        end
        stop_x();
    endtask
    task automatic rd(input logic [3:0] idx, output logic [7:0] q);
        logic a;
        start_x();
        byte_x({7'h44, 1'b0}, 1'b1, q, a);
        byte_x({4'h0, idx}, 1'b1, q, a);
        stop_x();
        start_x();
        byte_x({7'h44, 1'b1}, 1'b1, q, a);
        byte_x(8'hff, 1'b1, q, a);
        stop_x();
    endtask
endmodule
`default_nettype wire

// *** verification/light_proximity_sensor_ctrl_test.sv ***
`default_nettype none
module light_proximity_sensor_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic osc_tick = 1'b0;
    logic [15:0] adc_sample = 16'h0000;
    logic scl, sda_low, sda_line, sda_out, sda_oe_q, int_n_out, int_n_oe_q, ok;
    logic led_modulation_select_q, led_drive_out_q, conv_active_q;
    logic [2:0] sense_mode_q;
    logic [1:0] led_current_q, full_scale_q;
    logic [7:0] rq;
    logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
    logic [7:0] cfg_tab [4] = '{8'h4c, 8'h1d, 8'h6e, 8'h3f};
    int num_errors = 0;
    int check_count = 0;
    // open-drain data wire with pull-up
    assign sda_line = !(sda_low || sda_oe_q);
    always #25 clk_sys = !clk_sys;
    light_proximity_sensor_ctrl light_proximity_sensor_ctrl_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_q(sda_oe_q), .int_n_out(int_n_out),
        .int_n_oe_q(int_n_oe_q), .osc_tick(osc_tick), .adc_sample(adc_sample),
        .sense_mode_q(sense_mode_q), .led_modulation_select_q(led_modulation_select_q),
        .led_current_q(led_current_q), .full_scale_q(full_scale_q),
        .led_drive_out_q(led_drive_out_q), .conv_active_q(conv_active_q));
    i2c_host_model i2c_host_model_inst (
        .clk_sys(clk_sys), .sda_line(sda_line), .scl_q(scl), .sda_low_q(sda_low));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
        i2c_host_model_inst.rd(idx, rq);
        chk(rq, exp);
    endtask
    task automatic wrw(input logic [3:0] idx, input logic [15:0] d);
        i2c_host_model_inst.wr(7'h44, idx, d, ok);
        chk({7'h00, ok}, 8'h01);
    endtask
    // one conversion at the 4-bit length: sixteen oscillator pulses
    task automatic conv();
        repeat (16) begin
            @(negedge clk_sys) osc_tick = 1'b1;
            @(negedge clk_sys) osc_tick = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #2000000;
        num_errors++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < 9; i++) begin
            rdc(i[3:0], rst_tab[i]);
        end
        $display("test reset values done");
        i2c_host_model_inst.wr(7'h45, 4'h1, 16'h0f0f, ok);
        chk({7'h00, ok}, 8'h00);
        rdc(4'h1, 8'h00);
        $display("test foreign address done");
        for (int i = 0; i < 4; i++) begin
            wrw(4'h0, {cfg_tab[i], 8'h00});
            chk({7'h00, led_modulation_select_q}, {7'h00, cfg_tab[i][6]});
            chk({6'h00, led_current_q}, {6'h00, cfg_tab[i][5:4]});
            chk({6'h00, full_scale_q}, {6'h00, cfg_tab[i][1:0]});
            rdc(4'h1, cfg_tab[i]);
        end
        $display("test config codes done");
        adc_sample = 16'h000a;
        wrw(4'h0, 16'hbf60);
        chk({5'h00, sense_mode_q}, 8'h03);
        conv();
        chk({5'h00, sense_mode_q}, 8'h00);
        rdc(4'h2, 8'hfa);
        rdc(4'h3, 8'hff);
        adc_sample = 16'h0003;
        wrw(4'h0, 16'h3f80);
        conv();
        chk({7'h00, conv_active_q}, 8'h00);
        rdc(4'h2, 8'hfa);
        $display("test one shot done");
        wrw(4'h6, 16'h0005);
        adc_sample = 16'h000a;
        wrw(4'h0, 16'h3fa1);
        repeat (3) conv();
        chk({7'h00, int_n_oe_q}, 8'h00);
        conv();
        chk({7'h00, int_n_oe_q}, 8'h01);
        rdc(4'h0, 8'ha5);
        chk({7'h00, int_n_oe_q}, 8'h00);
        adc_sample = 16'h0004;
        conv();
        rdc(4'h2, 8'h04);
        chk({7'h00, int_n_oe_q}, 8'h00);
        chk({5'h00, sense_mode_q}, 8'h05);
        wrw(4'h0, 16'h3f00);
        $display("test interrupt done");
        close_out();
    end
endmodule
`default_nettype wire
